// >>> ast_baud_gen.sv
// Purpose: Bit-time enable pulse from the baud divisor
// Assumes: Divisor steady while a frame runs
// Notes: Counters preload whenever run is low, so a frame's first
//        bit lasts a full bit time despite the registered tick
`timescale 1ns/1ps
`default_nettype none
module ast_baud_gen (
   input wire logic clk,
   input wire logic rst,
   ast_baud_if.gen baud
);
   logic [ast_pkg::CNT_W-1:0] pre;
   logic [ast_pkg::DIV_W-1:0] div_cnt;
   logic tick;
   logic [ast_pkg::CNT_W-1:0] next_pre;
   logic [ast_pkg::DIV_W-1:0] next_div_cnt;
   logic next_tick;
   logic [ast_pkg::CNT_W-1:0] pre_last;

   always_comb begin
      pre_last = baud.high_speed ? ast_pkg::PRESCALE_HIGH_LAST
                                 : ast_pkg::PRESCALE_LOW_LAST;
      next_pre = pre + 4'h1;
      next_div_cnt = div_cnt;
      next_tick = 1'b0;
      if (!baud.run) begin
         next_pre = ast_pkg::PRESCALE_PRELOAD;
         next_div_cnt = ast_pkg::DIV_RESET;
      end else if (pre == pre_last) begin
         next_pre = ast_pkg::CNT_RESET;
         if (div_cnt == baud.divisor) begin
            next_div_cnt = ast_pkg::DIV_RESET;
            next_tick = 1'b1;
         end else begin
            next_div_cnt = div_cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pre <= ast_pkg::CNT_RESET;
         div_cnt <= ast_pkg::DIV_RESET;
         tick <= 1'b0;
      end else begin
         pre <= next_pre;
         div_cnt <= next_div_cnt;
         tick <= next_tick;
      end
   end

   assign baud.bit_tick = tick;

   // Tick is a single-cycle pulse
   chk_tick_single_pulse: assert property (@(posedge clk) disable iff (rst)
      tick |=> !tick)
      else $error("bit tick lasted more than one cycle");
endmodule
`default_nettype wire

// >>> ast_baud_if.sv
// Purpose: Carries baud settings out and bit ticks back
// Assumes: Single clock domain
// Notes: gen drives the tick, user drives the settings
`timescale 1ns/1ps
`default_nettype none
interface ast_baud_if;
   logic run;
   logic high_speed;
   logic [ast_pkg::DIV_W-1:0] divisor;
   logic bit_tick;
   modport gen (input run, input high_speed, input divisor, output bit_tick);
   modport user (output run, output high_speed, output divisor,
      input bit_tick);
endinterface
`default_nettype wire

// >>> ast_pkg.sv
// Purpose: Shared constants and types of the async serial transmitter
// Assumes: One 100 MHz core clock
// Notes: Counter and buffer reset values, line levels and prescale counts live here; flag resets stay in the modules
package ast_pkg;
   localparam int DATA_W = 8;
   localparam int CHAR_W = 9;
   localparam int DIV_W = 8;
   localparam int CNT_W = 4;
   // Bit-time prescale: core clocks per divisor step
   localparam logic [CNT_W-1:0] PRESCALE_LOW_LAST = 4'hF;
   localparam logic [CNT_W-1:0] PRESCALE_HIGH_LAST = 4'h3;
   // Idle preload makes up for the registered tick's extra cycle
   localparam logic [CNT_W-1:0] PRESCALE_PRELOAD = 4'h1;
   localparam logic [CNT_W-1:0] LAST_BIT_EIGHT = 4'h7;
   localparam logic [CNT_W-1:0] LAST_BIT_NINE = 4'h8;
   localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
   localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;
   localparam logic [CHAR_W-1:0] CHAR_RESET = 9'h000;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic LINE_START = 1'b0;
   // Gray codes along idle, start, data, stop
   typedef enum logic [1:0] {
      AST_IDLE = 2'h0,
      AST_START = 2'h1,
      AST_DATA = 2'h3,
      AST_STOP = 2'h2
   } ast_state_t;
endpackage

// >>> ast_rx_model.sv
// Purpose: Remote async receiver on the serial line
// Assumes: Bit time of BIT_CLKS core clocks, address detection on
// Notes: Samples mid-bit, so a one-clock skew still decodes
`timescale 1ns/1ps
`default_nettype none
module ast_rx_model #(
   parameter int BIT_CLKS = 4
) (
   input wire logic clk,
   input wire logic line,
   input wire logic nine,
   output logic [8:0] data,
   output logic [7:0] count,
   output logic frame_ok,
   output logic addr_mark
);
   int i;
   initial begin
      data = 9'h000;
      count = 8'h00;
      frame_ok = 1'b1;
      addr_mark = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   always begin
      @(negedge line);
      repeat (BIT_CLKS / 2) @(posedge clk);
      if (line !== 1'b0) frame_ok = 1'b0;
      data = 9'h000;
      for (i = 0; i < (nine ? 9 : 8); i++) begin
         repeat (BIT_CLKS) @(posedge clk);
         data[i] = line;
      end
      repeat (BIT_CLKS) @(posedge clk);
      if (line !== 1'b1) frame_ok = 1'b0;
      // Receiver in address mode marks a set ninth bit
      addr_mark = nine & data[8];
      count = count + 8'h01;
   end
endmodule
`default_nettype wire

// >>> ast_tx.sv
// Purpose: Async serial transmitter with holding buffer and shifter
// Assumes: Inputs synchronous to I_CORE_CLK; software follows setup
// Notes: Writes while the port is not active are ignored
//
// What this block does
// [RQ1] Shift-empty flag set when shifter idle, cleared on buffer transfer.
// [RQ2] Shift-empty flag stays clear until stop bit fully shifted out.
// [RQ3] Shift-empty flag is a read-only status output, no interrupt path.
// [RQ4] Shift register is internal; software sees only the holding buffer.
// [RQ5] Nine-bit enable sends nine data bits per character instead of eight.
// [RQ6] Ninth-bit field goes out as the last, most significant data bit.
// [RQ7] Software writes the ninth bit before writing the low eight bits.
// [RQ8] Buffer write captures all nine bits at once; no later sampling.
// [RQ9] Software sets divisor and high-speed select before transmitting.
// [RQ10] Software clears sync select and sets port enable for async use.
// [RQ11] Ninth bit is sent unchanged; receivers may treat it as address.
// [RQ12] Setting transmit enable sets the buffer-free flag.
// [RQ13] Interrupt request when flag, enable and both gates are set.
// [RQ14] Buffer write while enabled starts transmission of the character.
// [RQ15] Frame: low start, data LSB first, high stop; line high idle.
// [RQ16] Buffer-free flag set while buffer empty, cleared by a write.
`timescale 1ns/1ps
`default_nettype none
module ast_tx (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_SERIAL_PORT_ENABLE,
   input wire logic I_SYNC_MODE_SELECT,
   input wire logic I_TRANSMIT_ENABLE,
   input wire logic I_NINE_BIT_TX_ENABLE,
   input wire logic I_TX_NINTH_BIT,
   input wire logic [7:0] I_BAUD_DIVISOR,
   input wire logic I_BAUD_HIGH_SPEED,
   input wire logic I_TX_HOLDING_BUFFER_WR,
   input wire logic [7:0] I_TX_HOLDING_BUFFER_DATA,
   input wire logic I_TX_IRQ_ENABLE,
   input wire logic I_GLOBAL_IRQ_GATE,
   input wire logic I_PERIPHERAL_IRQ_GATE,
   output logic O_TX_LINE,
   output logic O_SHIFT_EMPTY_FLAG,
   output logic O_TX_BUFFER_FREE_FLAG,
   output logic O_TX_IRQ
);
   ////////////////////////////////////////////////////////////////////
   // Baud generator
   ast_baud_if baud ();
   ast_baud_gen u_baud (
      .clk(I_CORE_CLK),
      .rst(I_RST),
      .baud(baud)
   );

   ////////////////////////////////////////////////////////////////////
   // State
   ast_pkg::ast_state_t state;
   ast_pkg::ast_state_t next_state;
   logic hold_full;
   logic next_hold_full;
   logic [ast_pkg::CHAR_W-1:0] hold_data;
   logic [ast_pkg::CHAR_W-1:0] next_hold_data;
   logic [ast_pkg::CHAR_W-1:0] shifter;
   logic [ast_pkg::CHAR_W-1:0] next_shifter;
   logic [ast_pkg::CNT_W-1:0] bit_cnt;
   logic [ast_pkg::CNT_W-1:0] next_bit_cnt;
   logic nine_mode;
   logic next_nine_mode;
   logic next_line;
   logic next_empty;
   logic next_free;
   logic next_irq;
   logic active;
   logic wr_ok;
   logic load;
   logic tick;

   assign active = I_SERIAL_PORT_ENABLE && !I_SYNC_MODE_SELECT
                   && I_TRANSMIT_ENABLE;
   assign wr_ok = I_TX_HOLDING_BUFFER_WR && active;
   assign tick = baud.bit_tick;
   assign baud.run = (state != ast_pkg::AST_IDLE);
   assign baud.high_speed = I_BAUD_HIGH_SPEED;
   assign baud.divisor = I_BAUD_DIVISOR;

   // Transfer from buffer when the shifter is free or just finished
   assign load = active && hold_full && ((state == ast_pkg::AST_IDLE)
      || (state == ast_pkg::AST_STOP && tick)); // [RQ1]

   ////////////////////////////////////////////////////////////////////
   // Holding buffer
   always_comb begin
      next_hold_full = hold_full;
      next_hold_data = hold_data;
      if (!active) begin
         next_hold_full = 1'b0;
      end else begin
         if (load) begin
            next_hold_full = 1'b0;
         end
         // A write in the transfer cycle refills the buffer
         if (wr_ok) begin
            next_hold_full = 1'b1; // [RQ14] [RQ16]
            next_hold_data = {I_TX_NINTH_BIT,
                              I_TX_HOLDING_BUFFER_DATA}; // [RQ8]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Shifter; not reachable by software, only the buffer is  [RQ4]
   always_comb begin
      next_state = state;
      next_shifter = shifter;
      next_bit_cnt = bit_cnt;
      next_nine_mode = nine_mode;
      if (!active) begin
         next_state = ast_pkg::AST_IDLE;
      end else if (load) begin
         next_state = ast_pkg::AST_START;
         next_shifter = hold_data; // [RQ8]
         next_nine_mode = I_NINE_BIT_TX_ENABLE; // [RQ5]
         next_bit_cnt = ast_pkg::CNT_RESET;
      end else if (tick) begin
         unique case (state)
            ast_pkg::AST_IDLE: begin
               next_state = ast_pkg::AST_IDLE;
            end
            ast_pkg::AST_START: begin
               next_state = ast_pkg::AST_DATA;
            end
            ast_pkg::AST_DATA: begin
               // Ninth bit sits last, after the eight buffer bits
               next_shifter = {1'b0, shifter[ast_pkg::CHAR_W-1:1]}; // [RQ6]
               if (bit_cnt == (nine_mode ? ast_pkg::LAST_BIT_NINE
                                         : ast_pkg::LAST_BIT_EIGHT)) begin
                  next_state = ast_pkg::AST_STOP; // [RQ5]
               end else begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
            ast_pkg::AST_STOP: begin
               next_state = ast_pkg::AST_IDLE; // [RQ2]
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Line and flags, registered from next values
   always_comb begin
      unique case (next_state)
         ast_pkg::AST_IDLE: next_line = ast_pkg::LINE_IDLE; // [RQ15]
         ast_pkg::AST_START: next_line = ast_pkg::LINE_START; // [RQ15]
         ast_pkg::AST_DATA: next_line = next_shifter[0]; // [RQ15] [RQ11]
         ast_pkg::AST_STOP: next_line = ast_pkg::LINE_IDLE; // [RQ15]
      endcase
      // Status only: the empty flag below never feeds the interrupt  [RQ3]
      next_empty = (next_state == ast_pkg::AST_IDLE); // [RQ1] [RQ2]
      // Free while enabled and empty; enabling sets it  [RQ12] [RQ16]
      next_free = active && !next_hold_full;
      next_irq = next_free && I_TX_IRQ_ENABLE && I_GLOBAL_IRQ_GATE
                 && I_PERIPHERAL_IRQ_GATE; // [RQ13]
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         state <= ast_pkg::AST_IDLE;
         hold_full <= 1'b0;
         hold_data <= ast_pkg::CHAR_RESET;
         shifter <= ast_pkg::CHAR_RESET;
         bit_cnt <= ast_pkg::CNT_RESET;
         nine_mode <= 1'b0;
         O_TX_LINE <= ast_pkg::LINE_IDLE;
         O_SHIFT_EMPTY_FLAG <= 1'b1;
         O_TX_BUFFER_FREE_FLAG <= 1'b0;
         O_TX_IRQ <= 1'b0;
      end else begin
         state <= next_state;
         hold_full <= next_hold_full;
         hold_data <= next_hold_data;
         shifter <= next_shifter;
         bit_cnt <= next_bit_cnt;
         nine_mode <= next_nine_mode;
         O_TX_LINE <= next_line;
         O_SHIFT_EMPTY_FLAG <= next_empty;
         O_TX_BUFFER_FREE_FLAG <= next_free;
         O_TX_IRQ <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);

   chk_load_clears_empty: assert property ( // [RQ1]
      load |=> !O_SHIFT_EMPTY_FLAG && !O_TX_LINE)
      else $error("transfer did not clear empty flag with start bit");

   chk_empty_while_busy: assert property ( // [RQ2]
      (state == ast_pkg::AST_DATA || state == ast_pkg::AST_STOP)
      |-> !O_SHIFT_EMPTY_FLAG)
      else $error("empty flag set while a frame is on the line");

   chk_empty_line_idle: assert property ( // [RQ15]
      O_SHIFT_EMPTY_FLAG |-> O_TX_LINE)
      else $error("line low while shifter empty");

   chk_stop_bit_high: assert property ( // [RQ15]
      (state == ast_pkg::AST_STOP) |-> O_TX_LINE)
      else $error("stop bit not high");

   chk_ninth_bit_sent: assert property ( // [RQ5]
      (state == ast_pkg::AST_DATA && bit_cnt == ast_pkg::LAST_BIT_NINE)
      |-> nine_mode)
      else $error("ninth data bit sent in eight-bit mode");

   chk_ninth_bit_value: assert property ( // [RQ6]
      (state == ast_pkg::AST_DATA && bit_cnt == ast_pkg::LAST_BIT_NINE)
      |-> O_TX_LINE == shifter[0])
      else $error("ninth bit value wrong on line");

   chk_nine_captured: assert property ( // [RQ8]
      wr_ok |=> hold_data == {$past(I_TX_NINTH_BIT),
                              $past(I_TX_HOLDING_BUFFER_DATA)})
      else $error("holding buffer did not capture nine bits");

   chk_enable_sets_free: assert property ( // [RQ12]
      $rose(active) && !hold_full |=> O_TX_BUFFER_FREE_FLAG)
      else $error("enable did not set buffer-free flag");

   chk_irq_follows_gates: assert property ( // [RQ13]
      O_TX_IRQ == (O_TX_BUFFER_FREE_FLAG && $past(I_TX_IRQ_ENABLE
      && I_GLOBAL_IRQ_GATE && I_PERIPHERAL_IRQ_GATE)))
      else $error("interrupt request does not follow flag and gates");

   chk_irq_needs_free: assert property ( // [RQ13]
      O_TX_IRQ |-> O_TX_BUFFER_FREE_FLAG)
      else $error("interrupt request without buffer-free flag");

   chk_write_starts_tx: assert property ( // [RQ14]
      wr_ok && state == ast_pkg::AST_IDLE && !hold_full
      |-> ##1 active [*1] ##1 (!O_TX_LINE || !active))
      else $error("write did not start a frame");

   chk_write_clears_free: assert property ( // [RQ16]
      wr_ok && state != ast_pkg::AST_IDLE |=> !O_TX_BUFFER_FREE_FLAG)
      else $error("write did not clear buffer-free flag");
endmodule
`default_nettype wire

// >>> ast_tx_tb_top.sv
// Purpose: Self-checking bench of the async serial transmitter
// Assumes: Divisor 0 with high speed, so a bit lasts 4 clocks
// Notes: Inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module ast_tx_tb_top;
   logic clk = 1'b0, rst = 1'b1, serial_port_enable = 1'b0, sync = 1'b0, transmit_enable = 1'b0;
   logic nine = 1'b0, ninth = 1'b0, wr = 1'b0, hs = 1'b1;
   logic irqen = 1'b0, global_irq_gate = 1'b0, peripheral_irq_gate = 1'b0;
   logic [7:0] div = 8'h00, wdata = 8'h00;
   logic line, empty, free, irq, fok, amark;
   logic [8:0] rdata;
   logic [7:0] rcnt, ecnt;
   int errors = 0, n_tests = 0, c;
   always #5 clk = ~clk;
   ast_tx DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_SERIAL_PORT_ENABLE(serial_port_enable),
      .I_SYNC_MODE_SELECT(sync), .I_TRANSMIT_ENABLE(transmit_enable),
      .I_NINE_BIT_TX_ENABLE(nine), .I_TX_NINTH_BIT(ninth),
      .I_BAUD_DIVISOR(div), .I_BAUD_HIGH_SPEED(hs),
      .I_TX_HOLDING_BUFFER_WR(wr), .I_TX_HOLDING_BUFFER_DATA(wdata),
      .I_TX_IRQ_ENABLE(irqen), .I_GLOBAL_IRQ_GATE(global_irq_gate),
      .I_PERIPHERAL_IRQ_GATE(peripheral_irq_gate), .O_TX_LINE(line),
      .O_SHIFT_EMPTY_FLAG(empty), .O_TX_BUFFER_FREE_FLAG(free),
      .O_TX_IRQ(irq));
   ast_rx_model #(.BIT_CLKS(4)) rx (.clk(clk), .line(line), .nine(nine),
      .data(rdata), .count(rcnt), .frame_ok(fok), .addr_mark(amark));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Ninth bit set ahead of the data, then changed to catch late sampling
   task automatic send(input logic [7:0] d, input logic b9);
      ninth = b9;
      cyc(1);
      wr = 1'b1;
      wdata = d;
      cyc(1);
      wr = 1'b0;
      ninth = ~b9;
   endtask
   task automatic wait_done;
      int k;
      k = 0;
      c = 0;
      while (empty !== 1'b0 && k < 10) begin
         cyc(1);
         k++;
      end
      while (empty === 1'b0 && c < 300) begin
         cyc(1);
         c++;
      end
      // A frame that never starts or never ends is a mismatch
      if (k >= 10 || c >= 300) begin
         errors++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(line, 1'b1);
      chk(empty, 1'b1);
      chk(free, 1'b0);
      chk(irq, 1'b0);
   endtask
   task automatic t_enable;
      div = 8'h00;
      serial_port_enable = 1'b1;
      cyc(2);
      chk(free, 1'b0);
      transmit_enable = 1'b1;
      cyc(2);
      chk(free, 1'b1);
      irqen = 1'b1;
      global_irq_gate = 1'b1;
      cyc(2);
      chk(irq, 1'b0);
      peripheral_irq_gate = 1'b1;
      cyc(1);
      chk(irq, 1'b1);
   endtask
   task automatic t_char(input logic [7:0] d, input logic b9, input logic n9);
      nine = n9;
      send(d, b9);
      wait_done;
      ecnt = ecnt + 8'h01;
      // Empty low from start bit through the stop bit, one clock slack
      chk(9'((c >= (n9 ? 43 : 39)) && (c <= (n9 ? 45 : 41))), 9'h001);
      chk(rdata, {b9 & n9, d});
      chk(rcnt, ecnt);
      chk(amark, b9 & n9);
      chk(fok, 1'b1);
      chk(free, 1'b1);
      chk(irq, 1'b1);
   endtask
   task automatic t_chain;
      nine = 1'b0;
      send(8'h5A, 1'b0);
      cyc(3);
      send(8'hC3, 1'b0);
      cyc(3);
      chk(free, 1'b0);
      chk(irq, 1'b0);
      chk(empty, 1'b0);
      wait_done;
      ecnt = ecnt + 8'h02;
      chk(rcnt, ecnt);
      chk(rdata, 9'h0C3);
      chk(free, 1'b1);
   endtask
   task automatic t_refuse;
      sync = 1'b1;
      cyc(1);
      send(8'h00, 1'b0);
      cyc(10);
      chk(empty, 1'b1);
      chk(rcnt, ecnt);
      sync = 1'b0;
      cyc(2);
      chk(free, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      ecnt = 8'h00;
      cyc(2);
      rst = 1'b0;
      t_reset;
      t_enable;
      t_char(8'hA5, 1'b1, 1'b0);
      t_char(8'h3C, 1'b1, 1'b1);
      t_char(8'h81, 1'b0, 1'b1);
      t_char(8'hFF, 1'b0, 1'b0);
      t_chain;
      t_refuse;
      t_char(8'h01, 1'b0, 1'b0);
      report_and_stop;
   end
   // Run needs about 330 clocks; stop well beyond that
   initial begin
      #50000;
      errors++;
      report_and_stop;
   end
endmodule
`default_nettype wire
